// ===== design/reset_supervisor_watchdog.sv
// Reset supervisor and watchdog: merges four reset sources into one reset.
// Assumes SFR writes and reads as one-cycle strobes from the core, and that
// clk is the oscillator clock; clkEn low freezes every flip-flop.
//
// Operation
// - Any active reset source asserts the single internal reset.
// - Internal reset reinitialises registers and drives the logic module reset low.
// - Reset stays asserted 10 ms after supply returns above threshold.
// - Undervoltage detector enabled after power-up; software may disable it.
// - Undervoltage reset keeps working in idle and power-down modes.
// - Supply dips shorter than about 1 us cause no reset.
// - Four or more single-ended-zero samples set the USB bus reset flag.
// - With bus reset enable set, USB bus reset also resets the system.
// - Watchdog is a 22-bit counter advancing once per machine cycle.
// - Watchdog counter overflow generates internal reset.
// - Watchdog is enabled at power-up and after every reset.
// - Reload writes 00h..7Eh load low seven bits into counter top bits.
// - Writing zero to reload clears the whole watchdog counter.
// - Only key 55h disables the watchdog; any other key enables it.
// - Watchdog and reset circuitry keep running during idle mode.
// - Watchdog reset pulse lasts 12 times 2^15 oscillator periods.
// - Undervoltage disable is power control bit 5, high disables.
// - One machine cycle equals twelve oscillator periods.
`include "reset_supervisor_params.svh"
`timescale 1ns/100ps

module reset_supervisor_watchdog #(
  parameter logic [`RSW_PULSE_WIDTH-1:0] UV_HOLD_CYC =
    `RSW_PULSE_WIDTH'(`RSW_UV_HOLD_CYC),
  parameter logic [`RSW_PULSE_WIDTH-1:0] WD_PULSE_CYC =
    `RSW_PULSE_WIDTH'(`RSW_PULSE_OSC)
) (
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Reset sources from pins and analog blocks
  input wire logic resetPin_n,
  input wire logic lowSupply,
  input wire logic usbSe0,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  output logic [7:0] sfrRdData,
  // Reset and status outputs
  output logic internalReset,
  output logic logicModuleReset_n,
  output logic usbBusResetFlag,
  output logic watchdogEnabled
);

  localparam logic [4:0] GLITCH_CYC = 5'(`RSW_GLITCH_CYC);
  localparam logic [`RSW_WD_WIDTH-1:0] WD_TOP = '1;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic pinResetSync_n;
  logic lowSupplySync;
  logic usbSe0Sync;

  pin_sync #(.INIT(1'b0)) resetPinSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(resetPin_n),
    .syncOut(pinResetSync_n)
  );

  pin_sync #(.INIT(1'b0)) lowSupplySyncInst (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(lowSupply),
    .syncOut(lowSupplySync)
  );

  pin_sync #(.INIT(1'b0)) usbSe0SyncInst (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(usbSe0),
    .syncOut(usbSe0Sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Machine-cycle prescaler

  logic [3:0] oscCount;
  logic [3:0] next_oscCount;
  logic machineTick;
  logic next_machineTick;

  // Twelve oscillator periods per tick; not reset by the internal reset so
  // that the watchdog stays in step through a pulse
  always_comb begin
    next_oscCount = oscCount + 4'h1;
    next_machineTick = 1'b0;
    if (oscCount == `RSW_MC_DIV) begin
      next_oscCount = 4'h0;
      next_machineTick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oscCount <= 4'h0;
      machineTick <= 1'b0;
    end else if (clkEn) begin
      oscCount <= next_oscCount;
      machineTick <= next_machineTick;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Special function registers

  logic [7:0] keyReg;
  logic uvDisable;
  logic usbResetEnable;
  logic reloadStrobe;
  logic [6:0] reloadValue;
  logic [7:0] next_keyReg;
  logic next_uvDisable;
  logic next_usbResetEnable;
  logic next_usbBusResetFlag;
  logic next_reloadStrobe;
  logic [6:0] next_reloadValue;
  logic [7:0] next_sfrRdData;
  logic usbDetect;

  always_comb begin
    next_keyReg = keyReg;
    next_uvDisable = uvDisable;
    next_usbResetEnable = usbResetEnable;
    next_usbBusResetFlag = usbBusResetFlag;
    next_reloadStrobe = 1'b0;
    next_reloadValue = reloadValue;
    next_sfrRdData = 8'h00;
    if (sfrWr) begin
      if (sfrAddr == `RSW_ADDR_RELOAD) begin
        // Values above 7Eh are outside the documented range and ignored
        if (sfrWrData <= `RSW_RELOAD_MAX) begin
          next_reloadStrobe = 1'b1;
          next_reloadValue = sfrWrData[6:0];
        end
      end else if (sfrAddr == `RSW_ADDR_KEY) begin
        next_keyReg = sfrWrData;
      end else if (sfrAddr == `RSW_ADDR_PWRCTL) begin
        next_uvDisable = sfrWrData[`RSW_PWR_UVDIS_BIT];
      end else if (sfrAddr == `RSW_ADDR_USBEN) begin
        next_usbResetEnable = sfrWrData[`RSW_USB_RST_BIT];
      end else if (sfrAddr == `RSW_ADDR_USBSTA) begin
        if (sfrWrData[`RSW_USB_RST_BIT]) begin
          next_usbBusResetFlag = 1'b0;
        end
      end
    end
    // Detection wins over a clear in the same cycle
    if (usbDetect) begin
      next_usbBusResetFlag = 1'b1;
    end
    if (sfrRd) begin
      if (sfrAddr == `RSW_ADDR_KEY) begin
        next_sfrRdData = keyReg;
      end else if (sfrAddr == `RSW_ADDR_PWRCTL) begin
        next_sfrRdData[`RSW_PWR_UVDIS_BIT] = uvDisable;
      end else if (sfrAddr == `RSW_ADDR_USBEN) begin
        next_sfrRdData[`RSW_USB_RST_BIT] = usbResetEnable;
      end else if (sfrAddr == `RSW_ADDR_USBSTA) begin
        next_sfrRdData[`RSW_USB_RST_BIT] = usbBusResetFlag;
      end
    end
  end

  // Key and power control return to defaults on every internal reset, so the
  // watchdog and detector come back enabled; the USB enable and flag survive
  // so that a bus reset can be told apart after restart
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keyReg <= `RSW_KEY_RESET;
      uvDisable <= 1'b0;
      usbResetEnable <= 1'b0;
      usbBusResetFlag <= 1'b0;
      reloadStrobe <= 1'b0;
      reloadValue <= 7'h00;
      sfrRdData <= 8'h00;
    end else if (clkEn) begin
      if (internalReset) begin
        keyReg <= `RSW_KEY_RESET;
        uvDisable <= 1'b0;
        reloadStrobe <= 1'b0;
        reloadValue <= 7'h00;
        sfrRdData <= 8'h00;
      end else begin
        keyReg <= next_keyReg;
        uvDisable <= next_uvDisable;
        reloadStrobe <= next_reloadStrobe;
        reloadValue <= next_reloadValue;
        sfrRdData <= next_sfrRdData;
      end
      usbResetEnable <= next_usbResetEnable;
      usbBusResetFlag <= next_usbBusResetFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Undervoltage glitch filter and hold

  logic [4:0] glitchCount;
  logic [4:0] next_glitchCount;
  logic uvFiltered;
  logic next_uvFiltered;
  logic uvHoldBusy;

  // No idle or power-down input reaches this logic, so it runs in every mode
  always_comb begin
    next_glitchCount = 5'h00;
    next_uvFiltered = 1'b0;
    if (lowSupplySync && !uvDisable) begin
      next_glitchCount = glitchCount;
      if (glitchCount < GLITCH_CYC) begin
        next_glitchCount = glitchCount + 5'h01;
      end
      next_uvFiltered = (next_glitchCount >= GLITCH_CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      glitchCount <= 5'h00;
      uvFiltered <= 1'b0;
    end else if (clkEn) begin
      glitchCount <= next_glitchCount;
      uvFiltered <= next_uvFiltered;
    end
  end

  // Reloaded every cycle uvFiltered is high, so the hold runs from recovery
  hold_counter #(.WIDTH(`RSW_PULSE_WIDTH), .COUNT(UV_HOLD_CYC)) uvHold (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .start(uvFiltered),
    .busy(uvHoldBusy)
  );

  ////////////////////////////////////////////////////////////////////////
  // USB single-ended-zero detection

  logic [3:0] se0Count;
  logic [3:0] next_se0Count;
  logic next_usbDetect;

  always_comb begin
    next_se0Count = 4'h0;
    if (usbSe0Sync) begin
      next_se0Count = se0Count;
      if (se0Count < `RSW_SE0_COUNT) begin
        next_se0Count = se0Count + 4'h1;
      end
    end
    next_usbDetect = (next_se0Count >= `RSW_SE0_COUNT);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      se0Count <= 4'h0;
      usbDetect <= 1'b0;
    end else if (clkEn) begin
      se0Count <= next_se0Count;
      usbDetect <= next_usbDetect;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counter

  rsw_pkg::wd_state_t wdState;
  rsw_pkg::wd_state_t next_wdState;
  logic [`RSW_WD_WIDTH-1:0] wdCount;
  logic [`RSW_WD_WIDTH-1:0] next_wdCount;
  logic wdOverflow;
  logic next_wdOverflow;
  logic next_watchdogEnabled;
  logic wdPulseBusy;

  always_comb begin
    next_wdState = wdState;
    next_wdCount = wdCount;
    next_wdOverflow = 1'b0;
    case (wdState)
      rsw_pkg::WD_COUNT: begin
        if (keyReg == `RSW_KEY_DISABLE) begin
          next_wdState = rsw_pkg::WD_HALT;
        end else if (machineTick) begin
          next_wdCount = wdCount + 1'b1;
          if (wdCount == WD_TOP) begin
            next_wdOverflow = 1'b1;
            next_wdState = rsw_pkg::WD_PULSE;
          end
        end
      end
      rsw_pkg::WD_HALT: begin
        if (keyReg != `RSW_KEY_DISABLE) begin
          next_wdState = rsw_pkg::WD_COUNT;
        end
      end
      rsw_pkg::WD_PULSE: begin
        if (!wdPulseBusy && !wdOverflow) begin
          next_wdState = rsw_pkg::WD_COUNT;
        end
      end
      default: begin
        next_wdState = rsw_pkg::WD_COUNT;
      end
    endcase
    // A reload takes effect in any state outside the pulse
    if (reloadStrobe && wdState != rsw_pkg::WD_PULSE) begin
      next_wdCount = {reloadValue, `RSW_RELOAD_LSB'(0)};
    end
    // Reset from any other source clears the count and re-arms the watchdog
    if (internalReset && wdState != rsw_pkg::WD_PULSE) begin
      next_wdCount = '0;
      next_wdState = rsw_pkg::WD_COUNT;
    end
    next_watchdogEnabled = (next_wdState != rsw_pkg::WD_HALT);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdState <= rsw_pkg::WD_COUNT;
      wdCount <= '0;
      wdOverflow <= 1'b0;
      watchdogEnabled <= 1'b1;
    end else if (clkEn) begin
      wdState <= next_wdState;
      wdCount <= next_wdCount;
      wdOverflow <= next_wdOverflow;
      watchdogEnabled <= next_watchdogEnabled;
    end
  end

  hold_counter #(.WIDTH(`RSW_PULSE_WIDTH), .COUNT(WD_PULSE_CYC)) wdPulse (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .start(wdOverflow),
    .busy(wdPulseBusy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reset merge

  logic next_internalReset;

  // No idle input gates the watchdog or this merge, so both run in idle
  always_comb begin
    next_internalReset = !pinResetSync_n
      || uvFiltered || uvHoldBusy
      || (usbDetect && usbResetEnable)
      || wdOverflow || wdPulseBusy;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      internalReset <= 1'b1;
      logicModuleReset_n <= 1'b0;
    end else if (clkEn) begin
      internalReset <= next_internalReset;
      logicModuleReset_n <= !next_internalReset;
    end
  end

endmodule // reset_supervisor_watchdog

// ===== shared/reset_supervisor_params.svh
// Constants for the reset supervisor and watchdog: addresses, fields, times.
// Assumes a 25 MHz core clock that is also the oscillator clock.
`ifndef RESET_SUPERVISOR_PARAMS_SVH
`define RESET_SUPERVISOR_PARAMS_SVH

// Special function register addresses
`define RSW_ADDR_RELOAD 8'hA6
`define RSW_ADDR_KEY 8'hAE
`define RSW_ADDR_PWRCTL 8'h87
`define RSW_ADDR_USBSTA 8'hE9
`define RSW_ADDR_USBEN 8'hEA

// Field positions and values
`define RSW_PWR_UVDIS_BIT 5
`define RSW_USB_RST_BIT 6
`define RSW_KEY_DISABLE 8'h55
`define RSW_KEY_RESET 8'h00
`define RSW_RELOAD_MAX 8'h7E
`define RSW_RELOAD_LSB 15

// Watchdog geometry
`define RSW_WD_WIDTH 22
`define RSW_MC_DIV 4'hB
`define RSW_PULSE_WIDTH 19

// Times in their own units and the clock rate
`define RSW_CLK_HZ 64'd25000000
`define RSW_UV_HOLD_MS 64'd10
`define RSW_GLITCH_NS 64'd1000
`define RSW_PULSE_OSC 64'd393216

// Cycle counts derived from the times; least times round up
`define RSW_UV_HOLD_CYC ((`RSW_UV_HOLD_MS * `RSW_CLK_HZ + 64'd999) / 64'd1000)
`define RSW_GLITCH_CYC ((`RSW_GLITCH_NS * `RSW_CLK_HZ + 64'd999999999) / 64'd1000000000)

// Consecutive single-ended-zero samples that make a bus reset
`define RSW_SE0_COUNT 4'h4

`endif

// ===== shared/rsw_pkg.sv
// Types for the reset supervisor and watchdog.
// Included by the design files; holds no constants of its own.
package rsw_pkg;

  typedef enum logic [1:0] {
    WD_COUNT = 2'b00,
    WD_HALT = 2'b01,
    WD_PULSE = 2'b10
  } wd_state_t;

endpackage

// ===== design/pin_sync.sv
// Three-stage synchroniser for an input from outside the clock domain.
// The output follows only once the second and third stages agree.
`timescale 1ns/100ps

module pin_sync #(
  parameter logic INIT = 1'b0
) (
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Data
  input wire logic pinIn,
  output logic syncOut
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_syncOut;

  always_comb begin
    next_syncOut = syncOut;
    if (stage2 == stage3) begin
      next_syncOut = stage3;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
      syncOut <= INIT;
    end else if (clkEn) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= next_syncOut;
    end
  end

endmodule // pin_sync

// ===== design/hold_counter.sv
// Retriggerable hold timer: busy for COUNT cycles after start last seen.
// Start is expected from a register on the same clock.
`timescale 1ns/100ps

module hold_counter #(
  parameter int WIDTH = 19,
  parameter logic [WIDTH-1:0] COUNT = '1
) (
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Control
  input wire logic start,
  output logic busy
);

  logic [WIDTH-1:0] remain;
  logic [WIDTH-1:0] next_remain;
  logic next_busy;

  always_comb begin
    next_remain = remain;
    if (start) begin
      next_remain = COUNT;
    end else if (remain != '0) begin
      next_remain = remain - 1'b1;
    end
    next_busy = (next_remain != '0);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remain <= '0;
      busy <= 1'b0;
    end else if (clkEn) begin
      remain <= next_remain;
      busy <= next_busy;
    end
  end

endmodule // hold_counter

// ===== verification/reset_supervisor_watchdog_monitor.sv
// Port checker for the reset supervisor and watchdog.
// Bound to every instance of the top module; it sees only that module's ports.
`include "reset_supervisor_params.svh"
`timescale 1ns/100ps

module reset_supervisor_watchdog_monitor #(
  parameter logic [18:0] UV_HOLD_CYC = 19'h00014,
  parameter logic [18:0] WD_PULSE_CYC = 19'h0001E
) (
  // Clocking
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Reset sources
  input wire logic resetPin_n,
  input wire logic lowSupply,
  input wire logic usbSe0,
  // Register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdData,
  // Outputs
  input wire logic internalReset,
  input wire logic logicModuleReset_n,
  input wire logic usbBusResetFlag,
  input wire logic watchdogEnabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the supply dip length and of the detector disable bit
  logic [5:0] hiCnt, next_hiCnt;
  logic uvOff, next_uvOff;

  always_comb begin
    next_hiCnt = hiCnt;
    next_uvOff = uvOff;
    if (clkEn) begin
      next_hiCnt = !lowSupply ? 6'h00 : (hiCnt == 6'h3F ? hiCnt : hiCnt + 6'h01);
      if (internalReset) begin
        next_uvOff = 1'b0;
      end else if (sfrWr && sfrAddr == `RSW_ADDR_PWRCTL) begin
        next_uvOff = sfrWrData[5];
      end
    end
    if (sys_rst) begin
      next_hiCnt = 6'h00;
      next_uvOff = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    hiCnt <= next_hiCnt;
    uvOff <= next_uvOff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_keyWr;
    clkEn && sfrWr && !internalReset && sfrAddr == `RSW_ADDR_KEY;
  endsequence
  sequence s_pinLow;
    (clkEn && !resetPin_n)[*7];
  endsequence
  sequence s_se0;
    (clkEn && usbSe0)[*8];
  endsequence

  property p_inv;
    logicModuleReset_n != internalReset;
  endproperty
  property p_sysRst;
    disable iff (1'b0) sys_rst |=> internalReset && !logicModuleReset_n && watchdogEnabled
      && !usbBusResetFlag && sfrRdData == 8'h00;
  endproperty
  property p_pin;
    s_pinLow |=> internalReset && !logicModuleReset_n;
  endproperty
  property p_usbFlag;
    s_se0 |-> ##[1:3] usbBusResetFlag;
  endproperty
  property p_keyOff;
    s_keyWr ##0 sfrWrData == `RSW_KEY_DISABLE |-> ##[1:2] !watchdogEnabled;
  endproperty
  property p_keyOn;
    s_keyWr ##0 sfrWrData != `RSW_KEY_DISABLE |-> ##[1:2] watchdogEnabled;
  endproperty
  property p_rdNone;
    clkEn && !(sfrRd && sfrAddr inside {`RSW_ADDR_KEY, `RSW_ADDR_PWRCTL, `RSW_ADDR_USBSTA,
      `RSW_ADDR_USBEN}) |=> sfrRdData == 8'h00;
  endproperty
  property p_uv;
    hiCnt == 6'h28 && !uvOff |-> internalReset;
  endproperty

  a_inv: assert property (p_inv) else $error("module reset is not the inverse");
  a_sysRst: assert property (p_sysRst) else $error("bad state after reset");
  a_pin: assert property (p_pin) else $error("pin low gave no reset");
  a_usbFlag: assert property (p_usbFlag) else $error("bus reset flag not set");
  a_keyOff: assert property (p_keyOff) else $error("disable key ignored");
  a_keyOn: assert property (p_keyOn) else $error("other key did not enable");
  a_rdNone: assert property (p_rdNone) else $error("read data not zero");
  a_uv: assert property (p_uv) else $error("long supply dip gave no reset");
endmodule // reset_supervisor_watchdog_monitor

bind reset_supervisor_watchdog reset_supervisor_watchdog_monitor #(
  .UV_HOLD_CYC(UV_HOLD_CYC), .WD_PULSE_CYC(WD_PULSE_CYC)
) chk_u (
  .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .resetPin_n(resetPin_n),
  .lowSupply(lowSupply), .usbSe0(usbSe0), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
  .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .internalReset(internalReset),
  .logicModuleReset_n(logicModuleReset_n), .usbBusResetFlag(usbBusResetFlag),
  .watchdogEnabled(watchdogEnabled)
);

// ===== verification/reset_circuit_model.sv
// Model of the board reset circuit driving the reset pin.
// Assumes the oscillator runs from time zero; pin changes at falling edges.
`timescale 1ns/100ps

module reset_circuit_model #(
  parameter int HOLD_CYC = 25000
) (
  // Clocking
  input wire logic clk,
  // Later pin reset asked by the bench
  input wire logic pulseReq,
  // Pin
  output logic resetPin_n
);
  int cnt = 0;

  initial resetPin_n = 1'b0;

  // Power-up hold of 1 ms at 25 MHz, counted on the running oscillator
  always @(negedge clk) begin
    if (cnt < HOLD_CYC) cnt <= cnt + 1;
    resetPin_n <= !(pulseReq || cnt < HOLD_CYC);
  end
endmodule // reset_circuit_model

// ===== verification/testbench.sv
// Self-checking bench for the reset supervisor and watchdog.
// Assumes the design files, the shared header and the checker are compiled first.
`include "reset_supervisor_params.svh"
`timescale 1ns/100ps

module testbench;
  localparam logic [18:0] uvHold = 19'h00014;
  logic clk, sys_rst, clkEn, resetPin_n, lowSupply, usbSe0, sfrWr, sfrRd, pulseReq, seen;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd;
  logic internalReset, logicModuleReset_n, usbBusResetFlag, watchdogEnabled;
  logic [7:0] keys [5] = '{8'h55, 8'h54, 8'hD5, 8'h00, 8'h55};
  int errCount = 0;
  int checks = 0;
  int n;

  reset_supervisor_watchdog #(.UV_HOLD_CYC(uvHold), .WD_PULSE_CYC(19'h0001E)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .resetPin_n(resetPin_n),
    .lowSupply(lowSupply), .usbSe0(usbSe0), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
    .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .internalReset(internalReset),
    .logicModuleReset_n(logicModuleReset_n), .usbBusResetFlag(usbBusResetFlag),
    .watchdogEnabled(watchdogEnabled)
  );
  reset_circuit_model model_u (.clk(clk), .pulseReq(pulseReq), .resetPin_n(resetPin_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Accumulates any reset seen into the flag
  task automatic watch(input int c);
    repeat (c) begin
      @(negedge clk);
      seen = seen | internalReset;
    end
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWr = 1'b1;
    @(negedge clk);
    sfrWr = 1'b0;
    @(negedge clk);
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge clk);
    // Read data stands for one cycle only, so take it before the next edge
    d = sfrRdData;
    sfrRd = 1'b0;
    @(negedge clk);
  endtask
  // Counts cycles until the merged reset drops, bounded
  task automatic wait_rel();
    n = 0;
    while (internalReset !== 1'b0 && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 30000) errCount++;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clkEn = 1'b1;
    sys_rst = 1'b1;
    {lowSupply, usbSe0, sfrWr, sfrRd, pulseReq, seen} = 6'h00;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check1(internalReset, 1'b1);
    check1(logicModuleReset_n, 1'b0);
    check1(watchdogEnabled, 1'b1);
    wait_rel();
    check1(logicModuleReset_n, 1'b1);
    sfr_read(`RSW_ADDR_KEY, rd);
    check8(rd, 8'h00);
    $display("test power-up done");
    foreach (keys[i]) begin
      sfr_write(`RSW_ADDR_KEY, keys[i]);
      idle(2);
      check1(watchdogEnabled, keys[i] != `RSW_KEY_DISABLE);
      sfr_read(`RSW_ADDR_KEY, rd);
      check8(rd, keys[i]);
    end
    sfr_write(`RSW_ADDR_RELOAD, `RSW_RELOAD_MAX);
    sfr_write(`RSW_ADDR_RELOAD, 8'h00);
    sfr_read(`RSW_ADDR_RELOAD, rd);
    check8(rd, 8'h00);
    sfr_read(8'h12, rd);
    check8(rd, 8'h00);
    $display("test key and reload done");
    pulseReq = 1'b1;
    idle(10);
    check1(internalReset, 1'b1);
    check1(logicModuleReset_n, 1'b0);
    pulseReq = 1'b0;
    wait_rel();
    check1(watchdogEnabled, 1'b1);
    sfr_read(`RSW_ADDR_KEY, rd);
    check8(rd, 8'h00);
    $display("test pin reset done");
    lowSupply = 1'b1;
    watch(10);
    lowSupply = 1'b0;
    watch(40);
    check1(seen, 1'b0);
    lowSupply = 1'b1;
    idle(45);
    check1(internalReset, 1'b1);
    lowSupply = 1'b0;
    wait_rel();
    check1(n >= uvHold && n <= uvHold + 10, 1'b1);
    sfr_write(`RSW_ADDR_PWRCTL, 8'h20);
    sfr_read(`RSW_ADDR_PWRCTL, rd);
    check8(rd, 8'h20);
    lowSupply = 1'b1;
    watch(45);
    lowSupply = 1'b0;
    check1(seen, 1'b0);
    sfr_write(`RSW_ADDR_PWRCTL, 8'h00);
    sfr_write(`RSW_ADDR_RELOAD, 8'h1E);
    $display("test undervoltage done");
    usbSe0 = 1'b1;
    idle(2);
    usbSe0 = 1'b0;
    idle(10);
    check1(usbBusResetFlag, 1'b0);
    usbSe0 = 1'b1;
    watch(12);
    usbSe0 = 1'b0;
    idle(4);
    check1(usbBusResetFlag, 1'b1);
    check1(seen, 1'b0);
    sfr_read(`RSW_ADDR_USBSTA, rd);
    check8(rd, 8'h40);
    sfr_write(`RSW_ADDR_USBSTA, 8'h40);
    check1(usbBusResetFlag, 1'b0);
    sfr_write(`RSW_ADDR_USBEN, 8'h40);
    usbSe0 = 1'b1;
    idle(12);
    check1(internalReset, 1'b1);
    usbSe0 = 1'b0;
    wait_rel();
    $display("test usb reset done");
    tally_and_finish();
  end

  // Power-up hold plus a few hundred cycles of tests fit well inside this span
  initial begin
    repeat (40000) @(posedge clk);
    errCount++;
    tally_and_finish();
  end
endmodule // testbench
